// ---- hw/timer_pkg.sv ----
// Package for the down-counting period timer: register map, field
// positions, reset values, carrier types and the address decode helper.
// Assumes a 32-bit APB3 slave with an 8-bit byte address.
package timer_pkg;

  localparam int unsigned CNT_W = 16;
  localparam int unsigned PSC_W = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Byte offsets of the word registers
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PERIOD = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_RATIO_LSB = 0;
  localparam int unsigned CTRL_STOP_BIT = 4;
  localparam int unsigned CTRL_RELOAD_BIT = 5;
  localparam int unsigned CTRL_PSC_LSB = 8;

  // Interrupt status and mask field
  localparam int unsigned IRQ_EVENT_BIT = 0;

  // Reset values
  localparam logic [PSC_W-1:0] RST_RATIO = 4'h0;
  localparam logic RST_STOP = 1'b0;
  localparam logic [CNT_W-1:0] RST_PERIOD = 16'hffff;
  localparam logic [CNT_W-1:0] RST_COUNT = 16'hffff;
  localparam logic [PSC_W-1:0] RST_PSC = 4'h0;
  localparam logic RST_MASK = 1'b0;

  // Software-owned timer configuration
  typedef struct packed {
    logic stop;
    logic [PSC_W-1:0] ratio;
  } ctrl_cfg_t;

  // One APB request as seen by the slave
  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } apb_req_t;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] off);
    reg_hit = (addr == off);
  endfunction : reg_hit

endpackage : timer_pkg

// ---- hw/timer_prescaler.sv ----
// Prescaler of the period timer: counts down once per clock while running
// and emits a tick on each borrow. Assumes ratio and load come from the
// register block in the same clock domain.
`timescale 1ns/10ps
module timer_prescaler
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic load,
  input wire logic [PSC_W-1:0] ratio,
  output logic [PSC_W-1:0] psc_q,
  output logic tick
);

  logic [PSC_W-1:0] psc_d;

  // Borrow happens when a running prescaler sits at zero
  assign tick = run & ~load & (psc_q == '0);

  always_comb begin
    psc_d = psc_q;
    if (load) begin
      psc_d = ratio;
    end else if (run) begin
      psc_d = (psc_q == '0) ? ratio : psc_q - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_q <= RST_PSC;
    end else begin
      psc_q <= psc_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_psc_reload: assert property (tick |=> psc_q == $past(ratio))
    else $error("prescaler did not reload on borrow");

  a_psc_step: assert property (run && !load && psc_q != '0
                               |=> psc_q == $past(psc_q) - 1'b1)
    else $error("prescaler did not count down");

endmodule : timer_prescaler

// ---- hw/timer_counter.sv ----
// Main 16-bit down counter of the period timer with period reload on
// borrow. Assumes one decrement request per prescaler tick.
`timescale 1ns/10ps
module timer_counter
  import timer_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dec,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic [WIDTH-1:0] period,
  output logic [WIDTH-1:0] cnt_q,
  output logic borrow
);

  logic [WIDTH-1:0] cnt_d;

  // A software load takes the cycle; the decrement it displaces is lost
  assign borrow = dec & ~load & (cnt_q == '0);

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_val;
    end else if (dec) begin
      cnt_d = (cnt_q == '0) ? period : cnt_q - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= WIDTH'(RST_COUNT);
    end else begin
      cnt_q <= cnt_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cnt_step: assert property (dec && !load && cnt_q != '0
                               |=> cnt_q == $past(cnt_q) - 1'b1)
    else $error("counter did not step down on tick");

  a_cnt_idle: assert property (!dec && !load |=> $stable(cnt_q))
    else $error("counter moved without a tick");

endmodule : timer_counter

// ---- hw/period_timer.sv ----
// Down-counting period timer with APB3 register access and interrupt.
// Assumes a single clock pclk, an APB3 master, and that software clears
// sticky interrupt status by writing ones.
//
// Overview of operation
// - Counter register holds present 16-bit count
// - Period register holds 16-bit reload value
// - Counter borrow reloads count from period
// - Reload control bit copies period into counter
// - Control sets divide ratio and run/stop
// - Control register shows prescaler current count
// - Reset: ratio zero, timer running
// - Reset: period register all ones
// - Reset: counter register all ones
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
module period_timer
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic timer_event,
  output logic irq
);

  apb_req_t req;
  ctrl_cfg_t cfg_q;
  ctrl_cfg_t cfg_d;
  logic [CNT_W-1:0] period_q;
  logic [CNT_W-1:0] period_d;
  logic [CNT_W-1:0] count_reg;
  logic [PSC_W-1:0] psc_cnt;
  logic stat_q;
  logic stat_d;
  logic mask_q;
  logic mask_d;
  logic event_q;
  logic event_d;
  logic irq_q;
  logic irq_d;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] prdata_d;
  logic err_q;
  logic err_d;
  logic setup;
  logic wr_fire;
  logic hit_any;
  logic reload_req;
  logic cnt_wr;
  logic cnt_load;
  logic [CNT_W-1:0] cnt_load_val;
  logic tick;
  logic borrow;
  logic first_q;

  assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata};

  // Bus phases; the slave never stalls, so every access ends in one cycle
  assign setup = req.sel & ~req.en;
  assign wr_fire = req.sel & req.en & req.wr;
  assign pready = req.sel & req.en;
  assign pslverr = req.sel & req.en & err_q;
  assign prdata = prdata_q;
  assign timer_event = event_q;
  assign irq = irq_q;

  assign hit_any = reg_hit(req.addr, OFF_CTRL) | reg_hit(req.addr, OFF_PERIOD) |
                   reg_hit(req.addr, OFF_COUNT) | reg_hit(req.addr, OFF_IRQ_STAT) |
                   reg_hit(req.addr, OFF_IRQ_MASK);

  // Reload and count writes share the load path; they are different
  // addresses, so they can never collide in one cycle
  assign reload_req = wr_fire & reg_hit(req.addr, OFF_CTRL) &
                      req.wdata[CTRL_RELOAD_BIT];
  assign cnt_wr = wr_fire & reg_hit(req.addr, OFF_COUNT);
  assign cnt_load = reload_req | cnt_wr;
  assign cnt_load_val = reload_req ? period_q : req.wdata[CNT_W-1:0];

  // The ratio is taken before it is registered, so a reload bit
  // starts the prescaler from the ratio written in that same word
  timer_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .run(~cfg_q.stop),
    .load(reload_req),
    .ratio(cfg_d.ratio),
    .psc_q(psc_cnt),
    .tick(tick)
  );

  timer_counter #(
    .WIDTH(CNT_W)
  ) u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .dec(tick),
    .load(cnt_load),
    .load_val(cnt_load_val),
    .period(period_q),
    .cnt_q(count_reg),
    .borrow(borrow)
  );

  // Register writes and the interrupt path
  always_comb begin
    cfg_d = cfg_q;
    period_d = period_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr_fire && reg_hit(req.addr, OFF_CTRL)) begin
      cfg_d.ratio = req.wdata[CTRL_RATIO_LSB +: PSC_W];
      cfg_d.stop = req.wdata[CTRL_STOP_BIT];
    end
    if (wr_fire && reg_hit(req.addr, OFF_PERIOD)) begin
      period_d = req.wdata[CNT_W-1:0];
    end
    if (wr_fire && reg_hit(req.addr, OFF_IRQ_MASK)) begin
      mask_d = req.wdata[IRQ_EVENT_BIT];
    end
    if (wr_fire && reg_hit(req.addr, OFF_IRQ_STAT) && req.wdata[IRQ_EVENT_BIT]) begin
      stat_d = 1'b0;
    end
    // A borrow in the clearing cycle still sets the flag
    if (borrow) begin
      stat_d = 1'b1;
    end
    event_d = borrow;
    irq_d = stat_d & mask_d;
  end

  // Read data is captured in the setup cycle so it leaves a flip-flop
  always_comb begin
    prdata_d = prdata_q;
    err_d = err_q;
    if (setup) begin
      err_d = ~hit_any;
      prdata_d = '0;
      if (!req.wr) begin
        unique case (1'b1)
          reg_hit(req.addr, OFF_CTRL): begin
            prdata_d[CTRL_RATIO_LSB +: PSC_W] = cfg_q.ratio;
            prdata_d[CTRL_STOP_BIT] = cfg_q.stop;
            prdata_d[CTRL_PSC_LSB +: PSC_W] = psc_cnt;
          end
          reg_hit(req.addr, OFF_PERIOD): prdata_d[CNT_W-1:0] = period_q;
          reg_hit(req.addr, OFF_COUNT): prdata_d[CNT_W-1:0] = count_reg;
          reg_hit(req.addr, OFF_IRQ_STAT): prdata_d[IRQ_EVENT_BIT] = stat_q;
          reg_hit(req.addr, OFF_IRQ_MASK): prdata_d[IRQ_EVENT_BIT] = mask_q;
          default: prdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '{stop: RST_STOP, ratio: RST_RATIO};
      period_q <= RST_PERIOD;
      mask_q <= RST_MASK;
      stat_q <= 1'b0;
      event_q <= 1'b0;
      irq_q <= 1'b0;
      prdata_q <= '0;
      err_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      period_q <= period_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      event_q <= event_d;
      irq_q <= irq_d;
      prdata_q <= prdata_d;
      err_q <= err_d;
    end
  end

  // Marks the cycle before the first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd_setup(logic [ADDR_W-1:0] off);
    psel && !penable && !pwrite && paddr == off;
  endsequence

  sequence s_rd_access;
    psel && penable && pready;
  endsequence

  sequence s_wr_access(logic [ADDR_W-1:0] off);
    psel && penable && pwrite && paddr == off;
  endsequence

  sequence s_reload_write;
    psel && penable && pwrite && paddr == OFF_CTRL && pwdata[CTRL_RELOAD_BIT];
  endsequence

  sequence s_ctr_borrow;
    tick && !cnt_load && count_reg == '0;
  endsequence

  a_count_read: assert property (s_rd_setup(OFF_COUNT) ##1 s_rd_access
                                 |-> prdata[CNT_W-1:0] == $past(count_reg))
    else $error("count read returned wrong value");

  a_period_write: assert property (s_wr_access(OFF_PERIOD)
                                   |=> period_q == $past(pwdata[CNT_W-1:0]))
    else $error("period write not stored");

  a_borrow_reload: assert property (s_ctr_borrow
                                    |=> count_reg == $past(period_q))
    else $error("borrow did not reload the period");

  a_reload_bit: assert property (s_reload_write
                                 |=> count_reg == $past(period_q)
                                     && psc_cnt == $past(pwdata[CTRL_RATIO_LSB +: PSC_W]))
    else $error("reload bit did not copy the period");

  a_stop_holds: assert property (cfg_q.stop && !cnt_load ##1 cfg_q.stop
                                 |-> $stable(count_reg) && $stable(psc_cnt))
    else $error("stopped timer kept counting");

  a_psc_visible: assert property (s_rd_setup(OFF_CTRL)
                                  |=> prdata[CTRL_PSC_LSB +: PSC_W] == $past(psc_cnt))
    else $error("prescaler count not visible in control read");

  a_reset_ctrl: assert property (first_q |-> cfg_q.ratio == RST_RATIO && !cfg_q.stop)
    else $error("control not at reset value");

  a_reset_period: assert property (first_q |-> period_q == RST_PERIOD)
    else $error("period not at reset value");

  a_reset_count: assert property (first_q |-> count_reg == RST_COUNT)
    else $error("count not at reset value");

  a_tick_decrement: assert property (tick && !cnt_load && count_reg != '0
                                     |=> count_reg == $past(count_reg) - 1'b1)
    else $error("prescaler borrow did not decrement the counter");

  a_event_pulse: assert property (s_ctr_borrow |=> timer_event && stat_q && irq == mask_q)
    else $error("borrow did not raise the event");

  a_event_cause: assert property (timer_event |-> $past(borrow))
    else $error("event without a counter borrow");

  a_unmapped_err: assert property (psel && !penable && !hit_any ##1 psel && penable
                                   |-> pslverr && prdata == '0)
    else $error("unmapped access not flagged");

endmodule : period_timer

// ---- tb/tb.sv ----
// Self-checking bench for the period timer: register access, reload, period timing, interrupt.
// Assumes the timer_pkg register map and a zero-wait APB3 slave.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin n_fail++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module tb;
  import timer_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, timer_event, irq, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  int n_fail, n_checks, seed, gap, r, p, c;
  int ratios[$] = '{0, 1, 2, 15};

  period_timer DUT (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .timer_event(timer_event),
    .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // Control word: model side of the register layout
  function automatic logic [DATA_W-1:0] ctrl(int stop, int rel, int ratio, int psc);
    ctrl = 32'((stop << CTRL_STOP_BIT) | (rel << CTRL_RELOAD_BIT) |
               (ratio << CTRL_RATIO_LSB) | (psc << CTRL_PSC_LSB));
  endfunction : ctrl

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      $display("MISMATCH pready expected 1 seen 0");
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Bounded wait for the event pulse; n is the number of edges waited
  task automatic wait_event(output int n);
    for (n = 1; n < 2000; n++) begin
      @(posedge pclk);
      if (timer_event === 1'b1) break;
    end
    if (n == 2000) begin
      n_fail++;
      $display("MISMATCH timer_event expected 1 seen 0");
      print_verdict();
    end
  endtask : wait_event

  initial begin
    seed = 32'hcc83;
    n_fail = 0;
    n_checks = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;

    // Reset values; the counter already runs, so only its top is checked
    apb(1'b0, OFF_COUNT, 32'h0);
    `CHK("count after reset", 1'b1, (rd[15:0] > 16'hffc0) && (rd[31:16] == 16'h0))
    apb(1'b0, OFF_CTRL, 32'h0);
    `CHK("ctrl after reset", ctrl(0, 0, 0, 0), rd)
    apb(1'b0, OFF_PERIOD, 32'h0);
    `CHK("period after reset", 32'h0000ffff, rd)
    `CHK("slverr mapped", 1'b0, err)
    $display("test reset_values done");

    // Stopped timer: period and count hold what software wrote
    r = $unsigned($random(seed)) % 16;
    p = $unsigned($random(seed)) % 65536;
    c = $unsigned($random(seed)) % 65536;
    apb(1'b1, OFF_CTRL, ctrl(1, 0, 15 - r, 0));
    apb(1'b1, OFF_PERIOD, 32'hffff0000 | p);
    apb(1'b0, OFF_PERIOD, 32'h0);
    `CHK("period rw", 32'(p), rd)
    apb(1'b1, OFF_COUNT, 32'(c));
    repeat (30) @(posedge pclk);
    apb(1'b0, OFF_COUNT, 32'h0);
    `CHK("count held while stopped", 32'(c), rd)
    // Reload bit copies period into count and ratio into prescaler
    apb(1'b1, OFF_CTRL, ctrl(1, 1, r, 0));
    apb(1'b0, OFF_COUNT, 32'h0);
    `CHK("count after reload", 32'(p), rd)
    apb(1'b0, OFF_CTRL, 32'h0);
    `CHK("ctrl with prescaler", ctrl(1, 0, r, r), rd)
    $display("test registers done");

    // Period timing and interrupt for several divide ratios
    foreach (ratios[k]) begin
      r = ratios[k];
      p = 2 + $unsigned($random(seed)) % 10;
      apb(1'b1, OFF_IRQ_MASK, 32'h0);
      apb(1'b1, OFF_PERIOD, 32'(p));
      apb(1'b1, OFF_CTRL, ctrl(0, 1, r, 0));
      wait_event(gap);
      `CHK("irq masked", 1'b0, irq)
      @(posedge pclk);
      `CHK("event width", 1'b0, timer_event)
      wait_event(gap);
      `CHK("event spacing", (r + 1) * (p + 1) - 1, gap)
      apb(1'b1, OFF_IRQ_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      `CHK("irq unmasked", 1'b1, irq)
      apb(1'b1, OFF_CTRL, ctrl(1, 0, r, 0));
      apb(1'b0, OFF_COUNT, 32'h0);
      `CHK("count within period", 1'b1, rd <= 32'(p))
      apb(1'b0, OFF_IRQ_STAT, 32'h0);
      `CHK("status set", 32'h1, rd)
      apb(1'b1, OFF_IRQ_STAT, 32'h1);
      apb(1'b0, OFF_IRQ_STAT, 32'h0);
      `CHK("status cleared", 32'h0, rd)
      repeat (2) @(posedge pclk);
      `CHK("irq cleared", 1'b0, irq)
    end
    $display("test period_timing done");

    // Unmapped address: write ignored, read zero, error flagged
    apb(1'b1, 8'h14, 32'hdeadbeef);
    `CHK("slverr write", 1'b1, err)
    apb(1'b0, 8'h14, 32'h0);
    `CHK("slverr read", 1'b1, err)
    `CHK("unmapped read", 32'h0, rd)
    apb(1'b0, OFF_PERIOD, 32'h0);
    `CHK("period untouched", 32'(p), rd)
    $display("test unmapped done");
    print_verdict();
  end
endmodule : tb
